// ===== rtl/pms_dec_conv.sv
/*
 * binary to decimal ascii converter for the status response.
 * assumes start only while busy is low; emits digits then a terminator.
 */
`timescale 1ns/1ps
`default_nettype none
module pms_dec_conv #(
   parameter int W = 16,
   parameter int D = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // request
   input wire logic start,
   input wire logic [W-1:0] value,
   // character output
   output var logic busy,
   output var logic digitValid,
   output var logic [7:0] digit
);
   import pms_pkg::*;

   typedef enum logic [1:0] {CV_IDLE, CV_SHIFT, CV_EMIT, CV_TERM} pms_cv_t;

   localparam int CW = $clog2(W + 1);
   localparam int IW = $clog2(D + 1);

   pms_cv_t state_q;
   logic [W-1:0] bin_q;
   logic [4*D-1:0] bcd_q;
   logic [4*D-1:0] adjBcd;
   logic [CW-1:0] cnt_q;
   logic [IW-1:0] idx_q;
   logic lead_q;
   logic [3:0] nib;

   // add three to every nibble of five or more before a shift
   function automatic logic [4*D-1:0] adjust(input logic [4*D-1:0] b);
      logic [4*D-1:0] r;
      r = b;
      for (int i = 0; i < D; i++) begin
         if (r[4*i +: 4] >= 4'h5) begin
            r[4*i +: 4] = r[4*i +: 4] + 4'h3;
         end
      end
      return r;
   endfunction

   assign adjBcd = adjust(bcd_q);
   assign nib = bcd_q[4*idx_q +: 4];

   // =====================================================
   // sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= CV_IDLE;
         busy <= 1'b0;
         digitValid <= 1'b0;
         digit <= BYTE_RST;
         bin_q <= '0;
         bcd_q <= '0;
         cnt_q <= '0;
         idx_q <= '0;
         lead_q <= 1'b1;
      end else begin
         digitValid <= 1'b0;
         case (state_q)
            CV_IDLE: begin
               if (start) begin
                  bin_q <= value;
                  bcd_q <= '0;
                  cnt_q <= CW'(W);
                  state_q <= CV_SHIFT;
                  busy <= 1'b1;
               end
            end
            CV_SHIFT: begin
               bcd_q <= {adjBcd[4*D-2:0], bin_q[W-1]};
               bin_q <= {bin_q[W-2:0], 1'b0};
               cnt_q <= cnt_q - CW'(1);
               if (cnt_q == CW'(1)) begin
                  state_q <= CV_EMIT;
                  idx_q <= IW'(D - 1);
                  lead_q <= 1'b1;
               end
            end
            CV_EMIT: begin
               // leading zeros suppressed, the last digit always sent
               if (nib != 4'h0 || !lead_q || idx_q == '0) begin
                  digitValid <= 1'b1;
                  digit <= ASCII_ZERO | {4'h0, nib};
                  lead_q <= 1'b0;
               end
               if (idx_q == '0) begin
                  state_q <= CV_TERM;
               end else begin
                  idx_q <= idx_q - IW'(1);
               end
            end
            CV_TERM: begin
               digitValid <= 1'b1;
               digit <= TERM_CHAR;
               state_q <= CV_IDLE;
               busy <= 1'b0;
            end
            default: begin
               state_q <= CV_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================
   // checks
   property p_dec_char;
      @(posedge clk) disable iff (srst)
      digitValid |-> (digit == TERM_CHAR ||
         (digit >= ASCII_ZERO && digit <= ASCII_NINE));
   endproperty
   a_dec_char: assert property (p_dec_char)
      else $error("status response character not a digit or terminator");

   property p_dec_start;
      @(posedge clk) disable iff (srst)
      (start && !busy) |=> busy ##[1:40] digitValid;
   endproperty
   a_dec_start: assert property (p_dec_start)
      else $error("status conversion did not produce a character");

endmodule // pms_dec_conv
`default_nettype wire

// ===== rtl/pms_monitor_ctrl.sv
/*
 * monitor-mode controller and upper extended status bits of the
 * plotter command interpreter. commands arrive as decoded one-cycle
 * strobes from the interpreter; panel and link settings are levels on
 * this clock; the servo and terminal break come straight from pins.
 */
`timescale 1ns/1ps
`default_nettype none
module pms_monitor_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link configuration
   input wire logic hostOnBus,
   input wire logic listenOnly,
   input wire logic fullDuplex,
   input wire logic eavesdrop,
   input wire logic standbyOn,
   input wire logic bypassOn,
   input wire logic localMode,
   // front panel
   input wire logic panelKeyPress,
   input wire logic keyboardMode,
   input wire logic panelMonitorSet,
   input wire logic [1:0] panelMonitorMode,
   // interpreter commands
   input wire logic readStatusCmd,
   input wire logic endDiscardCmd,
   input wire logic panelTextCmd,
   input wire logic keyReadCmd,
   input wire logic monitorSelectCmd,
   input wire logic monitorParamValid,
   input wire logic [1:0] monitorParam,
   input wire logic ioConfigCmd,
   input wire logic [7:0] ioConfigBits,
   // character streams
   input wire logic hostRxValid,
   input wire logic [7:0] hostRxByte,
   input wire logic parseValid,
   input wire logic [7:0] parseByte,
   input wire logic respValid,
   input wire logic [7:0] respByte,
   // pins and lower status
   input wire logic servoFailPin,
   input wire logic termBreakPin,
   input wire logic [pms_pkg::LOW_W-1:0] lowStatus,
   // status
   output var logic [pms_pkg::STATUS_W-1:0] statusWord,
   output var logic statusBusy,
   output var logic [1:0] monitorMode,
   output var logic [1:0] panelDisplay,
   // outgoing characters
   output var logic hostTxValid,
   output var logic [7:0] hostTxByte,
   output var logic termTxValid,
   output var logic [7:0] termTxByte,
   // requests to the rest of the plotter
   output var logic clearBufferReq,
   output var logic haltReq,
   output var logic programmedOffReq,
   output var logic remoteReq
);
   import pms_pkg::*;

   // =====================================================
   // pin synchronisers
   logic servoS1_q, servoS2_q;
   logic brkS1_q, brkS2_q, brkS3_q;
   logic brkRise;

   always_ff @(posedge clk) begin
      if (srst) begin
         servoS1_q <= 1'b0;
         servoS2_q <= 1'b0;
         brkS1_q <= 1'b0;
         brkS2_q <= 1'b0;
         brkS3_q <= 1'b0;
      end else begin
         servoS1_q <= servoFailPin;
         servoS2_q <= servoS1_q;
         brkS1_q <= termBreakPin;
         brkS2_q <= brkS1_q;
         brkS3_q <= brkS2_q;
      end
   end

   assign brkRise = brkS2_q && !brkS3_q;

   // =====================================================
   // function key flag
   logic keyFlag_q;
   logic keySet, keyClr;

   assign keySet = panelKeyPress && keyboardMode;
   assign keyClr = readStatusCmd || endDiscardCmd || panelTextCmd ||
      keyReadCmd;

   // a key press in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (srst) begin
         keyFlag_q <= KEY_FLAG_RST;
      end else if (keySet) begin
         keyFlag_q <= 1'b1;
      end else if (keyClr) begin
         keyFlag_q <= 1'b0;
      end
   end

   logic [STATUS_W-1:0] statusNow;
   assign statusNow = {UNUSED_BITS, servoS2_q, keyFlag_q, lowStatus};

   always_ff @(posedge clk) begin
      if (srst) begin
         statusWord <= STATUS_RST;
      end else begin
         statusWord <= statusNow;
      end
   end

   // =====================================================
   // decimal status response
   logic convValid;
   logic [7:0] convChar;

   // snapshot taken before the read clears the key flag
   pms_dec_conv #(
      .W(STATUS_W),
      .D(DEC_DIGITS)
   ) u_dec (
      .clk(clk),
      .srst(srst),
      .start(readStatusCmd && !statusBusy),
      .value(statusNow),
      .busy(statusBusy),
      .digitValid(convValid),
      .digit(convChar)
   );

   // =====================================================
   // host mode requests
   logic hostReq;
   logic [1:0] hostMode;
   logic hostRefused;
   logic hostAccept;
   logic fromPanel_q;

   always_comb begin
      hostReq = 1'b0;
      hostMode = MODE_OFF;
      if (monitorSelectCmd) begin
         // out-of-range values are dropped
         hostReq = !monitorParamValid || monitorParam <= MODE_RECEIVE;
         hostMode = monitorParamValid ? monitorParam : MODE_OFF;
      end else if (ioConfigCmd) begin
         hostReq = 1'b1;
         if (!ioConfigBits[IOCFG_EN_BIT]) begin
            hostMode = MODE_OFF;
         end else if (ioConfigBits[IOCFG_RX_BIT]) begin
            hostMode = MODE_RECEIVE;
         end else begin
            hostMode = MODE_PARSE;
         end
      end
   end

   assign hostRefused = !hostOnBus && hostMode != MODE_OFF &&
      (standbyOn || bypassOn);
   assign hostAccept = hostReq && !fromPanel_q && !hostRefused;

   // =====================================================
   // monitor state
   always_ff @(posedge clk) begin
      if (srst) begin
         monitorMode <= MODE_OFF;
         fromPanel_q <= 1'b0;
         panelDisplay <= MODE_OFF;
      end else if (panelMonitorSet) begin
         monitorMode <= panelMonitorMode;
         fromPanel_q <= panelMonitorMode != MODE_OFF;
         panelDisplay <= panelMonitorMode;
      end else if (hostAccept) begin
         monitorMode <= hostMode;
      end
   end

   logic enabling;
   assign enabling = (panelMonitorSet && panelMonitorMode != MODE_OFF) ||
      (!panelMonitorSet && hostAccept && hostMode != MODE_OFF);

   always_ff @(posedge clk) begin
      if (srst) begin
         remoteReq <= 1'b0;
      end else begin
         remoteReq <= enabling && !hostOnBus && localMode;
      end
   end

   // =====================================================
   // terminal break
   always_ff @(posedge clk) begin
      if (srst) begin
         clearBufferReq <= 1'b0;
         haltReq <= 1'b0;
         programmedOffReq <= 1'b0;
      end else begin
         clearBufferReq <= brkRise && (hostOnBus ||
            (monitorMode != MODE_OFF && eavesdrop));
         haltReq <= brkRise && hostOnBus;
         programmedOffReq <= brkRise && !hostOnBus &&
            monitorMode != MODE_OFF && eavesdrop;
      end
   end

   // =====================================================
   // character routing
   logic anyResp;
   logic [7:0] respChar;
   logic monValid;
   logic [7:0] monChar;
   logic respToTerm;

   // status digits take the response path; another response in the same cycle is dropped
   assign anyResp = convValid || respValid;
   assign respChar = convValid ? convChar : respByte;
   assign monValid = (monitorMode == MODE_PARSE && parseValid) ||
      (monitorMode == MODE_RECEIVE && hostRxValid);
   assign monChar = monitorMode == MODE_PARSE ? parseByte : hostRxByte;
   assign respToTerm = monitorMode != MODE_OFF && (hostOnBus ?
      !listenOnly :
      (monitorMode == MODE_PARSE || !fullDuplex));

   // host traffic is never gated by monitoring, only copied
   always_ff @(posedge clk) begin
      if (srst) begin
         hostTxValid <= 1'b0;
         hostTxByte <= BYTE_RST;
      end else begin
         hostTxValid <= anyResp && !(hostOnBus && listenOnly);
         hostTxByte <= respChar;
      end
   end

   // no buffer: a monitored character wins a same-cycle collision
   always_ff @(posedge clk) begin
      if (srst) begin
         termTxValid <= 1'b0;
         termTxByte <= BYTE_RST;
      end else if (monValid) begin
         termTxValid <= 1'b1;
         termTxByte <= monChar;
      end else begin
         termTxValid <= anyResp && respToTerm;
         termTxByte <= respChar;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_key_set;
      keySet |-> ##2 statusWord[KEY_BIT];
   endproperty
   a_key_set: assert property (p_key_set)
      else $error("key press in keyboard mode did not set bit 9");

   property p_key_clr;
      (keyClr && !keySet) |=> !keyFlag_q;
   endproperty
   a_key_clr: assert property (p_key_clr)
      else $error("clearing command left bit 9 set");

   property p_servo;
      $rose(statusWord[SERVO_BIT]) |-> $past(servoFailPin, 3);
   endproperty
   a_servo: assert property (p_servo)
      else $error("servo bit rose without a servo failure");

   property p_unused;
      statusWord[STATUS_W-1:SERVO_BIT+1] == UNUSED_BITS;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused status bits not zero");

   property p_no_param;
      (monitorSelectCmd && !monitorParamValid && !fromPanel_q &&
         !panelMonitorSet) |=> monitorMode == MODE_OFF;
   endproperty
   a_no_param: assert property (p_no_param)
      else $error("select without parameter did not disable monitoring");

   property p_panel_lock;
      (fromPanel_q && !panelMonitorSet) |=> $stable(monitorMode);
   endproperty
   a_panel_lock: assert property (p_panel_lock)
      else $error("host changed a panel-set monitor mode");

   property p_refuse;
      (!hostOnBus && (standbyOn || bypassOn) && monitorMode == MODE_OFF &&
         !panelMonitorSet) |=> monitorMode == MODE_OFF;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("monitoring enabled while not programmed-on");

   property p_rx_copy;
      (monitorMode == MODE_RECEIVE && hostRxValid) |=>
         termTxValid && termTxByte == $past(hostRxByte);
   endproperty
   a_rx_copy: assert property (p_rx_copy)
      else $error("received character not copied to terminal");

   property p_bus_break;
      (brkRise && hostOnBus) |=> clearBufferReq && haltReq;
   endproperty
   a_bus_break: assert property (p_bus_break)
      else $error("break on bus host did not clear and halt");

   property p_full_duplex;
      (monitorMode == MODE_RECEIVE && !hostOnBus && fullDuplex &&
         !hostRxValid && anyResp) |=> hostTxValid && !termTxValid;
   endproperty
   a_full_duplex: assert property (p_full_duplex)
      else $error("full duplex response copied to terminal");

   c_parse_copy: cover property (monitorMode == MODE_PARSE && parseValid);
   c_status_read: cover property (readStatusCmd ##[1:40] convValid);
   c_eaves_break: cover property (programmedOffReq);

endmodule // pms_monitor_ctrl
`default_nettype wire

// ===== shared/pms_pkg.sv
/*
 * shared constants of the plotter monitor-mode controller and status word.
 * assumes one 25 MHz clock and a synchronous active-high reset.
 */
// Contract
// - function key pressed in keyboard mode sets status bit 9 (512).
// - status read, end discard, panel text or key read clears bit 9.
// - status bit 10 (1024) is 1 on servo failure, else 0.
// - status reported as decimal sum of set bit weights; bits 11-15 unused.
// - monitor select takes 0-2, default 0: off, parse, receive.
// - monitor select without parameter disables monitoring like value 0.
// - in any monitor mode, host data runs normally and is copied out.
// - parse monitoring copies each character to terminal when parsed.
// - receive monitoring copies each character to terminal on arrival.
// - io configuration bits 2 and 3 also enable or disable monitoring.
// - panel-enabled monitoring ignores host attempts to change or disable it.
// - host-enabled monitoring may be changed by panel or by host.
// - panel changes override host state; display shows panel-set state.
// - bus host: terminal input ignored except break, which clears and halts.
// - bus addressable: responses to host and terminal; listen-only: none.
// - serial host: monitoring enables only when standby and bypass off; code checks this for host commands only, not for panel selection.
// - serial host in local mode goes remote when monitoring enables.
// - serial: break clears buffer, goes programmed-off in eavesdrop only.
// - receive monitoring, full duplex: responses go to host only.
// - receive monitoring, half duplex: responses go to host and terminal.
// - parse monitoring: responses always copied to terminal; code drops one that meets a parsed character in the same cycle.
`default_nettype none
package pms_pkg;
   // =====================================================
   // status word layout
   localparam int STATUS_W = 16;
   localparam int LOW_W = 9;
   localparam int KEY_BIT = 9;
   localparam int SERVO_BIT = 10;
   localparam int DEC_DIGITS = 5;
   localparam logic [4:0] UNUSED_BITS = 5'h00;
   localparam logic KEY_FLAG_RST = 1'b0;
   localparam logic [STATUS_W-1:0] STATUS_RST = 16'h0000;
   // =====================================================
   // monitor modes and io configuration bits
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_PARSE = 2'h1;
   localparam logic [1:0] MODE_RECEIVE = 2'h2;
   localparam int IOCFG_EN_BIT = 2;
   localparam int IOCFG_RX_BIT = 3;
   // =====================================================
   // response characters
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_NINE = 8'h39;
   localparam logic [7:0] TERM_CHAR = 8'h0D;
   localparam logic [7:0] BYTE_RST = 8'h00;
endpackage
`default_nettype wire

// ===== tb/pms_host_term.sv
/*
 * host computer and terminal model for the monitor controller bench.
 * assumes host characters arrive as one-cycle strobes on clk and that
 * the bench asks for a terminal break as a plain level.
 */
`timescale 1ns/1ps
`default_nettype none
module pms_host_term (
   // clock
   input wire logic clk,
   // characters sent to the host
   input wire logic hostTxValid,
   input wire logic [7:0] hostTxByte,
   // terminal side
   input wire logic breakReq,
   output var logic termBreakPin,
   // decoded status reply
   output var logic statusDone,
   output var logic [16:0] statusValue
);
   import pms_pkg::*;
   logic [16:0] digitAcc_q = 17'h00000;
   // =====================================================
   // terminal break: a line level with no relation to clk
   always_comb termBreakPin = breakReq;
   // =====================================================
   // host reply parser: digits build a decimal value, CR closes it
   always @(posedge clk) begin
      statusDone <= 1'b0;
      if (hostTxValid && hostTxByte == TERM_CHAR) begin
         statusValue <= digitAcc_q;
         statusDone <= 1'b1;
         digitAcc_q <= 17'h00000;
      end else if (hostTxValid && hostTxByte >= ASCII_ZERO &&
            hostTxByte <= ASCII_NINE) begin
         digitAcc_q <= 17'(digitAcc_q * 10 + (hostTxByte - ASCII_ZERO));
      end
   end
endmodule // pms_host_term
`default_nettype wire

// ===== tb/tb_plotter_monitor_status.sv
/*
 * self-checking bench of the monitor controller and status word.
 * assumes the design contract of one-cycle command strobes and
 * registered outputs; host polls are spaced far tighter than a real host.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checkCount++; \
   if ((g) !== (e)) begin \
      nMismatch++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
   end \
end
module tb_plotter_monitor_status;
   import pms_pkg::*;
   logic clk, srst, breakReq, termBreakPin, statusDone;
   logic hostOnBus, listenOnly, fullDuplex, eavesdrop, standbyOn, bypassOn;
   logic localMode, keyboardMode, monitorParamValid, servoFailPin;
   logic [1:0] panelMonitorMode, monitorParam, monitorMode, panelDisplay;
   logic [7:0] cmd, ioConfigBits, chByte, hostTxByte, termTxByte;
   logic [2:0] chVal;
   logic [LOW_W-1:0] lowStatus;
   logic [STATUS_W-1:0] statusWord;
   logic [16:0] statusValue;
   logic [7:0] expByte;
   logic [16:0] expStat;
   logic statusBusy, hostTxValid, termTxValid;
   logic clearBufferReq, haltReq, programmedOffReq, remoteReq;
   logic [7:0] termQ[$];
   logic [16:0] statQ[$];
   int nMismatch = 0, checkCount = 0, cyc = 0, k, w, seedDummy;
   int reqCnt[5] = '{0, 0, 0, 0, 0};
   int snap[5];
   // =====================================================
   // design and partner
   pms_monitor_ctrl dut_u (.clk(clk), .srst(srst), .hostOnBus(hostOnBus),
      .listenOnly(listenOnly), .fullDuplex(fullDuplex),
      .eavesdrop(eavesdrop), .standbyOn(standbyOn), .bypassOn(bypassOn),
      .localMode(localMode), .panelKeyPress(cmd[7]),
      .keyboardMode(keyboardMode), .panelMonitorSet(cmd[6]),
      .panelMonitorMode(panelMonitorMode), .readStatusCmd(cmd[0]),
      .endDiscardCmd(cmd[1]), .panelTextCmd(cmd[2]), .keyReadCmd(cmd[3]),
      .monitorSelectCmd(cmd[4]), .monitorParamValid(monitorParamValid),
      .monitorParam(monitorParam), .ioConfigCmd(cmd[5]),
      .ioConfigBits(ioConfigBits), .hostRxValid(chVal[0]),
      .hostRxByte(chByte), .parseValid(chVal[1]), .parseByte(chByte),
      .respValid(chVal[2]), .respByte(chByte), .servoFailPin(servoFailPin),
      .termBreakPin(termBreakPin), .lowStatus(lowStatus),
      .statusWord(statusWord), .statusBusy(statusBusy),
      .monitorMode(monitorMode), .panelDisplay(panelDisplay),
      .hostTxValid(hostTxValid), .hostTxByte(hostTxByte),
      .termTxValid(termTxValid), .termTxByte(termTxByte),
      .clearBufferReq(clearBufferReq), .haltReq(haltReq),
      .programmedOffReq(programmedOffReq), .remoteReq(remoteReq));
   pms_host_term host_u (.clk(clk), .hostTxValid(hostTxValid),
      .hostTxByte(hostTxByte), .breakReq(breakReq),
      .termBreakPin(termBreakPin), .statusDone(statusDone),
      .statusValue(statusValue));
   // =====================================================
   // clock, watcher, pulse counters, timeout
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (termTxValid === 1'b1) begin
         if (termQ.size() == 0)
            `CHK("termTx spurious", 1'b0, 1'b1)
         else begin
            expByte = termQ.pop_front();
            `CHK("termTxByte", expByte, termTxByte)
         end
      end
      if (statusDone === 1'b1) begin
         expStat = statQ.pop_front();
         `CHK("status value", expStat, statusValue)
      end
      reqCnt[0] += int'(clearBufferReq === 1'b1);
      reqCnt[1] += int'(haltReq === 1'b1);
      reqCnt[2] += int'(programmedOffReq === 1'b1);
      reqCnt[3] += int'(remoteReq === 1'b1);
      reqCnt[4] += int'(hostTxValid === 1'b1);
      cyc++;
      if (cyc == 20000) begin
         nMismatch++;
         giveVerdict();
      end
   end
   // =====================================================
   // driver tasks
   task settle;
      repeat (3) @(negedge clk);
   endtask
   task strobe(input int i);
      @(negedge clk);
      cmd[i] = 1'b1;
      @(negedge clk);
      cmd = 8'h00;
      settle();
   endtask
   task sel(input logic v, input logic [1:0] p);
      monitorParamValid = v;
      monitorParam = p;
      strobe(4);
   endtask
   task panel(input logic [1:0] m);
      panelMonitorMode = m;
      strobe(6);
   endtask
   task ioCfg(input logic [7:0] b);
      ioConfigBits = b;
      strobe(5);
   endtask
   task sendCh(input int i, input bit copy);
      @(negedge clk);
      chByte = 8'h41 + 8'($urandom_range(25));
      chVal[i] = 1'b1;
      if (copy)
         termQ.push_back(chByte);
      @(negedge clk);
      chVal = 3'h0;
      settle();
   endtask
   // poll spacing scaled down from the host's tenth of a second
   task readStatus(input logic [15:0] v);
      statQ.push_back({1'b0, v});
      strobe(0);
      `CHK("statusBusy", 1'b1, statusBusy)
      for (w = 0; w < 40 && statusBusy !== 1'b0; w++)
         @(negedge clk);
      settle();
   endtask
   task brk;
      snap = reqCnt;
      @(negedge clk);
      breakReq = 1'b1;
      repeat (8) @(negedge clk);
      breakReq = 1'b0;
      settle();
   endtask
   task giveVerdict;
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // =====================================================
   // scenarios
   initial begin
      {hostOnBus, listenOnly, fullDuplex, eavesdrop, standbyOn} = 5'h00;
      {bypassOn, localMode, keyboardMode, monitorParamValid} = 4'h0;
      {servoFailPin, breakReq, panelMonitorMode, monitorParam} = 6'h00;
      {cmd, ioConfigBits, chByte, chVal, lowStatus} = 36'h000000000;
      srst = 1'b1;
      seedDummy = $urandom(32'hC4C9123E);
      repeat (6) @(negedge clk);
      srst = 1'b0;
      `CHK("statusWord", STATUS_RST, statusWord)
      lowStatus = 9'($urandom);
      keyboardMode = 1'b1;
      for (k = 0; k < 4; k++) begin
         strobe(7);
         `CHK("key flag", 1'b1, statusWord[KEY_BIT])
         if (k == 0)
            readStatus({6'h00, 1'b1, lowStatus});
         else
            strobe(k);
         `CHK("key flag", 1'b0, statusWord[KEY_BIT])
      end
      keyboardMode = 1'b0;
      strobe(7);
      `CHK("key flag", 1'b0, statusWord[KEY_BIT])
      servoFailPin = 1'b1;
      repeat (5) @(negedge clk);
      `CHK("statusWord", {7'h02, lowStatus}, statusWord)
      readStatus({7'h02, lowStatus});
      servoFailPin = 1'b0;
      repeat (5) @(negedge clk);
      `CHK("servo bit", 1'b0, statusWord[SERVO_BIT])
      localMode = 1'b1;
      snap = reqCnt;
      sel(1'b1, MODE_RECEIVE);
      `CHK("monitorMode", MODE_RECEIVE, monitorMode)
      `CHK("remote pulses", snap[3] + 1, reqCnt[3])
      sel(1'b1, 2'h3);
      `CHK("monitorMode", MODE_RECEIVE, monitorMode)
      sel(1'b0, MODE_RECEIVE);
      `CHK("monitorMode", MODE_OFF, monitorMode)
      standbyOn = 1'b1;
      sel(1'b1, MODE_PARSE);
      `CHK("monitorMode", MODE_OFF, monitorMode)
      {standbyOn, bypassOn} = 2'h1;
      sel(1'b1, MODE_PARSE);
      `CHK("monitorMode", MODE_OFF, monitorMode)
      bypassOn = 1'b0;
      ioCfg(8'h0C);
      `CHK("monitorMode", MODE_RECEIVE, monitorMode)
      ioCfg(8'h00);
      `CHK("monitorMode", MODE_OFF, monitorMode)
      ioCfg(8'h04);
      `CHK("monitorMode", MODE_PARSE, monitorMode)
      sendCh(1, 1'b1);
      sendCh(0, 1'b0);
      fullDuplex = 1'b1;
      sendCh(2, 1'b1);
      sel(1'b1, MODE_RECEIVE);
      sendCh(0, 1'b1);
      sendCh(1, 1'b0);
      sendCh(2, 1'b0);
      fullDuplex = 1'b0;
      sendCh(2, 1'b1);
      {hostOnBus, fullDuplex} = 2'h3;
      sendCh(2, 1'b1);
      listenOnly = 1'b1;
      snap = reqCnt;
      sendCh(2, 1'b0);
      `CHK("host responses", snap[4], reqCnt[4])
      listenOnly = 1'b0;
      brk();
      `CHK("clear pulses", snap[0] + 1, reqCnt[0])
      `CHK("halt pulses", snap[1] + 1, reqCnt[1])
      hostOnBus = 1'b0;
      eavesdrop = 1'b1;
      brk();
      `CHK("clear pulses", snap[0] + 1, reqCnt[0])
      `CHK("off pulses", snap[2] + 1, reqCnt[2])
      eavesdrop = 1'b0;
      brk();
      `CHK("clear pulses", snap[0], reqCnt[0])
      `CHK("off pulses", snap[2], reqCnt[2])
      panel(MODE_PARSE);
      `CHK("panelDisplay", MODE_PARSE, panelDisplay)
      sel(1'b1, MODE_RECEIVE);
      ioCfg(8'h00);
      `CHK("monitorMode", MODE_PARSE, monitorMode)
      panel(MODE_OFF);
      sel(1'b1, MODE_RECEIVE);
      `CHK("panelDisplay", MODE_OFF, panelDisplay)
      sel(1'b1, MODE_PARSE);
      `CHK("monitorMode", MODE_PARSE, monitorMode)
      panel(MODE_RECEIVE);
      `CHK("monitorMode", MODE_RECEIVE, monitorMode)
      sel(1'b1, MODE_OFF);
      `CHK("monitorMode", MODE_RECEIVE, monitorMode)
      `CHK("pending term", 0, termQ.size())
      `CHK("pending status", 0, statQ.size())
      giveVerdict();
   end
endmodule // tb_plotter_monitor_status
`default_nettype wire
